// >>> design/rci_insert_buf.sv
// Function
// - Writing 0 then 1 to control bit 2 flushes all buffered cell data.
// - Control bit 1 reads 1 when a whole further cell fits, else 0.
// - With enable bit 4 set, each cell leaving the buffer raises an interrupt.
// - An enabled cell-leaving event drives the active-low interrupt output low.
// - Each cell leaving the buffer sets status bit 4.
// - With control bit 0 set, the next committed word starts a new cell.
// - Cells are 14 words, each written as four bytes, MSB first.
// - Each complete cell not discarded by a flush is forwarded to the receive cell queue.
// - Reads of the byte-lane data registers return extraction buffer data.
`timescale 1ns/1ps
`default_nettype none

module rci_insert_buf
    import rci_pkg::*;
#(
    parameter int CELLS = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] up_addr,
    input wire logic up_wr,
    input wire logic up_rd,
    input wire logic [7:0] up_wdata,
    output logic [7:0] up_rdata_ff,
    output logic irq_n_ff,
    input wire logic [31:0] extract_word,
    output logic [31:0] cell_word_ff,
    output logic cell_valid_ff,
    output logic cell_soc_ff,
    output logic cell_eoc_ff,
    input wire logic cell_ready
);

    localparam int MEM_WORDS = CELLS * RCI_CELL_WORDS;
    localparam int AW = $clog2(MEM_WORDS);
    localparam int CW = $clog2(CELLS + 1);
    localparam int SW = (CELLS > 1) ? $clog2(CELLS) : 1;

    if (CELLS < 1 || CELLS > 64) begin : g_bad_cells
        $error("rci_insert_buf: CELLS must be 1..64");
    end

    // ****************************************
    // Register decode
    // ****************************************
    logic wr_ctrl, wr_en, rd_status, wr_data, commit;
    logic [1:0] lane;
    assign wr_ctrl = up_wr && (up_addr == RCI_MEM_CTRL_OFS);
    assign wr_en = up_wr && (up_addr == RCI_IRQ_ENABLE_OFS);
    assign rd_status = up_rd && (up_addr == RCI_IRQ_STATUS_OFS);
    assign wr_data = up_wr && (up_addr >= RCI_DATA_B3_OFS)
        && (up_addr <= RCI_DATA_B0_OFS);
    // Byte 3 sits at the lowest address, so the lane is the inverted offset
    assign lane = ~up_addr[1:0];
    assign commit = wr_data && (lane == 2'd0);

    logic soc_ff, flush_n_ff;
    logic [1:0] ext_ctl_ff;
    logic [7:0] irq_en_ff, irq_status_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            soc_ff <= RCI_MEM_CTRL_RST[RCI_CTL_SOC_BIT];
            flush_n_ff <= RCI_MEM_CTRL_RST[RCI_CTL_FLUSH_N_BIT];
            ext_ctl_ff <= RCI_MEM_CTRL_RST[RCI_CTL_EXT_RST_N_BIT:
                RCI_CTL_EXT_CLAV_BIT];
        end else if (wr_ctrl) begin
            soc_ff <= up_wdata[RCI_CTL_SOC_BIT];
            flush_n_ff <= up_wdata[RCI_CTL_FLUSH_N_BIT];
            ext_ctl_ff <= up_wdata[RCI_CTL_EXT_RST_N_BIT:
                RCI_CTL_EXT_CLAV_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_en_ff <= RCI_IRQ_ENABLE_RST;
        end else if (wr_en) begin
            irq_en_ff <= up_wdata & RCI_IRQ_USED_MASK;
        end
    end

    // ****************************************
    // Word assembly, MSB byte first
    // ****************************************
    // Lane 0 commits straight from the bus, so it needs no register
    logic [7:0] asm_ff [1:RCI_WORD_BYTES-1];
    for (genvar b = 1; b < RCI_WORD_BYTES; b++) begin : g_lane
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                asm_ff[b] <= 8'h00;
            end else if (wr_data && lane == 2'(b)) begin
                asm_ff[b] <= up_wdata;
            end
        end
    end

    // ****************************************
    // Cell store
    // ****************************************
    logic [31:0] mem [MEM_WORDS];
    logic [CW-1:0] cells_ff;
    logic [SW-1:0] wr_cell_ff, rd_cell_ff;
    logic [3:0] wr_word_ff, rd_word_ff, idx;
    logic room, wr_ok, wr_last, load, rd_last, ins_event;
    logic [AW-1:0] wr_addr, rd_addr;

    // Cells still being loaded do not count, so room reflects a free slot
    assign room = cells_ff < CW'(CELLS);
    assign idx = soc_ff ? 4'd0 : wr_word_ff;
    assign wr_ok = commit && room && flush_n_ff;
    assign wr_last = wr_ok && (idx == 4'(RCI_CELL_WORDS - 1));
    assign wr_addr = AW'(wr_cell_ff * RCI_CELL_WORDS + idx);
    assign rd_addr = AW'(rd_cell_ff * RCI_CELL_WORDS + rd_word_ff);
    assign load = flush_n_ff && (cells_ff != '0)
        && (!cell_valid_ff || cell_ready);
    assign rd_last = load && (rd_word_ff == 4'(RCI_CELL_WORDS - 1));
    assign ins_event = rd_last;

    always_ff @(posedge ref_clk) begin
        if (wr_ok) begin
            mem[wr_addr] <= {asm_ff[3], asm_ff[2], asm_ff[1], up_wdata};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !flush_n_ff) begin
            wr_word_ff <= 4'd0;
            wr_cell_ff <= '0;
        end else if (wr_last) begin
            wr_word_ff <= 4'd0;
            wr_cell_ff <= (wr_cell_ff == SW'(CELLS - 1)) ? '0
                : SW'(wr_cell_ff + 1'b1);
        end else if (wr_ok) begin
            wr_word_ff <= 4'(idx + 4'd1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !flush_n_ff) begin
            rd_word_ff <= 4'd0;
            rd_cell_ff <= '0;
        end else if (rd_last) begin
            rd_word_ff <= 4'd0;
            rd_cell_ff <= (rd_cell_ff == SW'(CELLS - 1)) ? '0
                : SW'(rd_cell_ff + 1'b1);
        end else if (load) begin
            rd_word_ff <= 4'(rd_word_ff + 4'd1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || !flush_n_ff) begin
            cells_ff <= '0;
        end else if (wr_last && !rd_last) begin
            cells_ff <= CW'(cells_ff + 1'b1);
        end else if (rd_last && !wr_last) begin
            cells_ff <= CW'(cells_ff - 1'b1);
        end
    end

    // ****************************************
    // Output toward the receive cell queue
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst || !flush_n_ff) begin
            cell_valid_ff <= 1'b0;
            cell_word_ff <= 32'h0000_0000;
            cell_soc_ff <= 1'b0;
            cell_eoc_ff <= 1'b0;
        end else if (load) begin
            cell_valid_ff <= 1'b1;
            cell_word_ff <= mem[rd_addr];
            cell_soc_ff <= (rd_word_ff == 4'd0);
            cell_eoc_ff <= rd_last;
        end else if (cell_ready) begin
            cell_valid_ff <= 1'b0;
        end
    end

    // ****************************************
    // Status and interrupt
    // ****************************************
    logic overflow;
    assign overflow = commit && flush_n_ff && !room;

    // A set in the same cycle as the clearing read wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_status_ff <= RCI_IRQ_STATUS_RST;
        end else begin
            irq_status_ff[RCI_IRQ_INS_CELL_BIT] <= ins_event
                || (irq_status_ff[RCI_IRQ_INS_CELL_BIT] && !rd_status);
            irq_status_ff[RCI_IRQ_INS_OVF_BIT] <= overflow
                || (irq_status_ff[RCI_IRQ_INS_OVF_BIT] && !rd_status);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_n_ff <= 1'b1;
        end else begin
            irq_n_ff <= ~|(irq_status_ff & irq_en_ff);
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            up_rdata_ff <= 8'h00;
        end else if (up_rd) begin
            unique case (up_addr)
                RCI_IRQ_STATUS_OFS: up_rdata_ff <= irq_status_ff;
                RCI_IRQ_ENABLE_OFS: up_rdata_ff <= irq_en_ff;
                RCI_MEM_CTRL_OFS: up_rdata_ff <= {3'b000, ext_ctl_ff,
                    flush_n_ff, room, soc_ff};
                RCI_DATA_B3_OFS, RCI_DATA_B3_OFS + 8'h01,
                RCI_DATA_B3_OFS + 8'h02, RCI_DATA_B0_OFS:
                    up_rdata_ff <= extract_word[8*lane +: 8];
                default: up_rdata_ff <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence ins_evt_seq;
        ins_event && irq_en_ff[RCI_IRQ_INS_CELL_BIT];
    endsequence

    flush_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        !flush_n_ff |=> cells_ff == '0 && !cell_valid_ff)
        else $error("flush left data in buffer");
    room_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_rd && up_addr == RCI_MEM_CTRL_OFS
        |=> up_rdata_ff[RCI_CTL_ROOM_BIT] == ($past(cells_ff) < CW'(CELLS)))
        else $error("room flag wrong");
    irq_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        ins_evt_seq |-> ##2 !irq_n_ff)
        else $error("interrupt not raised");
    status_set_a: assert property (@(posedge ref_clk) disable iff (rst)
        ins_event |=> irq_status_ff[RCI_IRQ_INS_CELL_BIT])
        else $error("insertion status not set");
    soc_restart_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_ok && soc_ff && !wr_last |=> wr_word_ff == 4'd1)
        else $error("start of cell not honoured");
    cell_full_a: assert property (@(posedge ref_clk) disable iff (rst)
        wr_last && !rd_last |=> cells_ff == $past(cells_ff) + 1'b1)
        else $error("cell not counted after 14 words");
    extract_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        up_rd && up_addr == RCI_DATA_B3_OFS
        |=> up_rdata_ff == $past(extract_word[31:24]))
        else $error("data read not from extraction side");
    rur_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
        rd_status && !ins_event |=> !irq_status_ff[RCI_IRQ_INS_CELL_BIT])
        else $error("status not cleared on read");
    irq_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        (irq_status_ff & irq_en_ff) == 8'h00 |=> irq_n_ff)
        else $error("interrupt stuck low");
    forward_a: assert property (@(posedge ref_clk) disable iff (rst)
        load |=> cell_valid_ff)
        else $error("cell word not forwarded");

endmodule

`default_nettype wire

// >>> design/rci_pkg.sv
package rci_pkg;

    // ****************************************
    // Register offsets on the 8-bit port
    // ****************************************
    localparam logic [7:0] RCI_IRQ_STATUS_OFS = 8'h0b;
    localparam logic [7:0] RCI_IRQ_ENABLE_OFS = 8'h0f;
    localparam logic [7:0] RCI_MEM_CTRL_OFS = 8'h13;
    localparam logic [7:0] RCI_DATA_B3_OFS = 8'h14;
    localparam logic [7:0] RCI_DATA_B0_OFS = 8'h17;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int RCI_CTL_SOC_BIT = 0;
    localparam int RCI_CTL_ROOM_BIT = 1;
    localparam int RCI_CTL_FLUSH_N_BIT = 2;
    localparam int RCI_CTL_EXT_CLAV_BIT = 3;
    localparam int RCI_CTL_EXT_RST_N_BIT = 4;
    localparam int RCI_IRQ_INS_OVF_BIT = 2;
    localparam int RCI_IRQ_INS_CELL_BIT = 4;
    localparam logic [7:0] RCI_IRQ_USED_MASK = 8'h3f;

    // ****************************************
    // Reset values and cell geometry
    // ****************************************
    localparam logic [7:0] RCI_MEM_CTRL_RST = 8'h17;
    localparam logic [7:0] RCI_IRQ_ENABLE_RST = 8'h00;
    localparam logic [7:0] RCI_IRQ_STATUS_RST = 8'h00;
    localparam int RCI_CELL_BYTES = 56;
    localparam int RCI_WORD_BYTES = 4;
    localparam int RCI_CELL_WORDS = RCI_CELL_BYTES / RCI_WORD_BYTES;

    typedef logic [7:0] rci_byte_type;

endpackage

// >>> sim/rci_queue_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Receive cell queue stand-in
// ****************************************
module rci_queue_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic [31:0] cell_word,
    input wire logic cell_valid,
    input wire logic cell_soc,
    input wire logic cell_eoc,
    output logic cell_ready
);
    logic [33:0] got [$];

    // Stalls on demand so the buffer must keep whole cells waiting
    assign cell_ready = !hold;

    always @(posedge ref_clk) begin
        if (!rst && cell_valid && cell_ready) begin
            got.push_back({cell_soc, cell_eoc, cell_word});
        end
    end
endmodule

`default_nettype wire

// >>> sim/test_rx_cell_insertion_buffer.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin \
    miscompares++; $display("BAD %s exp %h got %h", nm, ex, gt); end end

module test_rx_cell_insertion_buffer;
    import rci_pkg::*;
    logic ref_clk = 1'b0;
    logic rst, up_wr, up_rd, hold, irq_n, cell_valid, cell_soc, cell_eoc;
    logic cell_ready;
    logic [7:0] up_addr, up_wdata, up_rdata;
    logic [31:0] extract_word, cell_word;
    int tests_run = 0;
    int miscompares = 0;
    // Address in the upper byte, expected read value in the lower
    logic [15:0] rows [8] = '{16'h1317, 16'h0f00, 16'h0b00, 16'h0000,
        16'h1411, 16'h1522, 16'h1633, 16'h1744};

    always #10 ref_clk = !ref_clk;

    rci_insert_buf dut (.ref_clk(ref_clk), .rst(rst), .up_addr(up_addr),
        .up_wr(up_wr), .up_rd(up_rd), .up_wdata(up_wdata),
        .up_rdata_ff(up_rdata), .irq_n_ff(irq_n),
        .extract_word(extract_word), .cell_word_ff(cell_word),
        .cell_valid_ff(cell_valid), .cell_soc_ff(cell_soc),
        .cell_eoc_ff(cell_eoc), .cell_ready(cell_ready));

    rci_queue_model model (.ref_clk(ref_clk), .rst(rst), .hold(hold),
        .cell_word(cell_word), .cell_valid(cell_valid),
        .cell_soc(cell_soc), .cell_eoc(cell_eoc), .cell_ready(cell_ready));

    // ****************************************
    // Register port and cell helpers
    // ****************************************
    function automatic logic [31:0] wv(input int c, input int i);
        return {8'hc0 + 8'(c), 8'(i), 8'h5a, 8'(i * 7)};
    endfunction

    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // An idle cycle between strobes keeps each pulse a clean single cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        up_addr = a;
        up_wdata = d;
        up_wr = 1'b1;
        @(negedge ref_clk);
        up_wr = 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] ex);
        up_addr = a;
        up_rd = 1'b1;
        @(negedge ref_clk);
        up_rd = 1'b0;
        `CHK("register read", ex, up_rdata)
        @(negedge ref_clk);
    endtask

    // Software polls the room flag before each cell
    task automatic wait_room();
        for (int t = 0; t < 400; t++) begin
            up_addr = RCI_MEM_CTRL_OFS;
            up_rd = 1'b1;
            @(negedge ref_clk);
            up_rd = 1'b0;
            @(negedge ref_clk);
            if (up_rdata[RCI_CTL_ROOM_BIT] === 1'b1) return;
        end
        miscompares++;
        stop_test();
    endtask

    task automatic load(input int c, input int n);
        logic [31:0] w;
        wait_room();
        wr(RCI_MEM_CTRL_OFS, 8'h17);
        for (int i = 0; i < n; i++) begin
            w = wv(c, i);
            for (int b = 0; b < 4; b++) begin
                wr(RCI_DATA_B3_OFS + 8'(b), w[31 - 8 * b -: 8]);
            end
            if (i == 0) begin
                wr(RCI_MEM_CTRL_OFS, 8'h16);
            end
        end
    endtask

    task automatic chk_cell(input int k, input int c);
        logic [33:0] want;
        for (int i = 0; i < RCI_CELL_WORDS; i++) begin
            want = {i == 0, i == RCI_CELL_WORDS - 1, wv(c, i)};
            `CHK("cell word", want, model.got[k + i])
        end
    endtask

    task automatic wait_words(input int n);
        for (int t = 0; t < 400 && model.got.size() < n; t++) begin
            @(negedge ref_clk);
        end
        if (model.got.size() < n) begin
            miscompares++;
            stop_test();
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        up_addr = 8'h00;
        up_wdata = 8'h00;
        up_wr = 1'b0;
        up_rd = 1'b0;
        hold = 1'b1;
        extract_word = 32'h11223344;
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        for (int r = 0; r < 8; r++) begin
            rdchk(rows[r][15:8], rows[r][7:0]);
        end
        wr(RCI_MEM_CTRL_OFS, 8'h13);
        wr(RCI_MEM_CTRL_OFS, 8'h17);
        wr(RCI_IRQ_ENABLE_OFS, 8'h10);
        rdchk(RCI_IRQ_ENABLE_OFS, 8'h10);
        load(1, 14);
        load(2, 14);
        rdchk(RCI_MEM_CTRL_OFS, 8'h14);
        // A word written with no room is dropped and flagged
        wr(RCI_DATA_B0_OFS, 8'hee);
        `CHK("irq idle", 1'b1, irq_n)
        hold = 1'b0;
        wait_words(28);
        chk_cell(0, 1);
        chk_cell(14, 2);
        repeat (2) @(negedge ref_clk);
        `CHK("irq raised", 1'b0, irq_n)
        rdchk(RCI_IRQ_STATUS_OFS, 8'h14);
        `CHK("irq released", 1'b1, irq_n)
        rdchk(RCI_IRQ_STATUS_OFS, 8'h00);
        rdchk(RCI_MEM_CTRL_OFS, 8'h16);
        // A full cell stalled behind the queue is thrown away by the flush
        hold = 1'b1;
        load(3, 14);
        wr(RCI_MEM_CTRL_OFS, 8'h12);
        wr(RCI_MEM_CTRL_OFS, 8'h16);
        hold = 1'b0;
        repeat (40) @(negedge ref_clk);
        `CHK("words after flush", 28, model.got.size())
        rdchk(RCI_IRQ_STATUS_OFS, 8'h00);
        // A start mark mid-cell restarts the cell at word zero
        load(9, 3);
        load(4, 14);
        wait_words(42);
        chk_cell(28, 4);
        repeat (2) @(negedge ref_clk);
        `CHK("irq second cell", 1'b0, irq_n)
        stop_test();
    end
endmodule

`default_nettype wire
